// ---- brpf_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "brpf_defines.svh"
// ==========================================================================
// port checker for the prefetch sizing block
module brpf_checker (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_cfg_rvalid,
  input wire logic i_p2p_bridging,
  input wire logic i_pri_flow_through,
  input wire logic i_sec_flow_through,
  input wire logic i_pri_read_start,
  input wire logic i_sec_read_start,
  input wire logic o_req_valid,
  input wire logic i_req_ready,
  input wire brpf_pkg::brpf_port_e o_req_port,
  input wire brpf_pkg::brpf_dwords_t o_req_dwords
);
  import brpf_pkg::*;
  logic rd_inc;
  logic rd_max;
  logic [6:0] pri_lim_reg;
  logic [6:0] sec_lim_reg;
  // doubleword limit of a written maximum field; zero selects 64
  function automatic logic [6:0] lim_of(input logic [7:0] d);
    return (d[5:1] == 5'h00) ? 7'h40 : {1'b0, d[5:1], 1'b0};
  endfunction
  // shadow of the programmed maxima, taken from the write strobes
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pri_lim_reg <= 7'(`BRPF_MAX_RESET);
      sec_lim_reg <= 7'(`BRPF_MAX_RESET);
    end
    else if (i_cfg_wr)
    begin
      if (i_cfg_addr == `BRPF_OFF_PRI_MAX_PREFETCH)
        pri_lim_reg <= lim_of(i_cfg_wdata);
      if (i_cfg_addr == `BRPF_OFF_SEC_MAX_PREFETCH)
        sec_lim_reg <= lim_of(i_cfg_wdata);
    end
  end
  // decode which register a read is aimed at
  assign rd_inc = i_cfg_rd && i_cfg_addr == `BRPF_OFF_SEC_INC_PREFETCH;
  assign rd_max = i_cfg_rd && (i_cfg_addr == `BRPF_OFF_PRI_MAX_PREFETCH ||
                               i_cfg_addr == `BRPF_OFF_SEC_MAX_PREFETCH);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // register read port
  property p_rd_answer;
    i_cfg_rd |=> o_cfg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_max_bits;
    rd_max |=> o_cfg_rdata[0] == 1'b0 && o_cfg_rdata[7:6] == 2'h0;
  endproperty
  a_max_bits: assert property (p_max_bits)
    else $error("maximum count fixed bits not zero");
  property p_inc_bits;
    rd_inc |=> o_cfg_rdata[0] == 1'b0 && o_cfg_rdata[7:6] == 2'h0;
  endproperty
  a_inc_bits: assert property (p_inc_bits)
    else $error("incremental register spare bits not zero");
  property p_unmapped;
    i_cfg_rd && !rd_inc && !rd_max |=> o_cfg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  // request stream
  property p_req_hold;
    o_req_valid && !i_req_ready |=> o_req_valid && $stable(o_req_dwords) && $stable(o_req_port);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed while stalled");
  property p_no_empty;
    o_req_valid |-> o_req_dwords != 12'h000;
  endproperty
  a_no_empty: assert property (p_no_empty)
    else $error("zero sized request");
  property p_pri_cap;
    o_req_valid && o_req_port == BRPF_PORT_PRI && i_p2p_bridging && !i_pri_flow_through
      |-> o_req_dwords <= {5'h00, pri_lim_reg};
  endproperty
  a_pri_cap: assert property (p_pri_cap)
    else $error("primary request above cap");
  property p_sec_cap;
    o_req_valid && o_req_port == BRPF_PORT_SEC && i_p2p_bridging && !i_sec_flow_through
      |-> o_req_dwords <= {5'h00, sec_lim_reg};
  endproperty
  a_sec_cap: assert property (p_sec_cap)
    else $error("secondary request above cap");
  sequence s_pri_launch;
    i_pri_read_start && !i_sec_read_start && !o_req_valid;
  endsequence
  sequence s_pri_answer;
    o_req_valid && o_req_port == BRPF_PORT_PRI;
  endsequence
  property p_pri_launch;
    s_pri_launch |-> ##[2:3] s_pri_answer;
  endproperty
  a_pri_launch: assert property (p_pri_launch)
    else $error("primary read gave no request");
endmodule
bind brpf_prefetch_ctrl brpf_checker brpf_checker_i (.i_clk, .i_rstn, .i_cfg_wr, .i_cfg_rd,
  .i_cfg_addr, .i_cfg_wdata,
  .o_cfg_rdata, .o_cfg_rvalid, .i_p2p_bridging, .i_pri_flow_through, .i_sec_flow_through,
  .i_pri_read_start, .i_sec_read_start, .o_req_valid, .i_req_ready, .o_req_port, .o_req_dwords);
`default_nettype wire

// ---- brpf_defines.svh ----
`ifndef BRPF_DEFINES_SVH
`define BRPF_DEFINES_SVH

// ==========================================================================
// configuration space offsets (byte addresses)
`define BRPF_OFF_SEC_INC_PREFETCH 8'h4b
`define BRPF_OFF_PRI_MAX_PREFETCH 8'h4c
`define BRPF_OFF_SEC_MAX_PREFETCH 8'h4d

// ==========================================================================
// field positions
`define BRPF_SEC16_BIT 1
`define BRPF_INC_MSB 5
`define BRPF_INC_LSB 2
`define BRPF_MAX_MSB 5
`define BRPF_MAX_WR_LSB 1

// ==========================================================================
// reset values
`define BRPF_SEC_INC_RESET 8'h00
`define BRPF_MAX_RESET 8'h20

// ==========================================================================
// sizing constants: doubleword amounts, a line count and the queue depth
`define BRPF_MAX_ZERO_DWORDS 7'h40
`define BRPF_INC_UNIT_DWORDS 4
`define BRPF_SIXTEEN_LINES 5'h10
`define BRPF_FIFO_DEPTH 32

`endif

// ---- brpf_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module brpf_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  logic load_out;

  // ==========================================================================
  // flow control; the output register is one extra stage of storage
  assign o_ready = (count_reg != (AW+1)'(DEPTH));
  assign load_out = !o_valid || i_ready;
  assign pop = load_out && (count_reg != '0);
  assign push = i_valid && o_ready && !(load_out && count_reg == '0);

  // storage array written by index
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= i_data;
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // registered output stage, bypassed straight from input when array is empty
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else if (load_out)
    begin
      if (count_reg != '0)
      begin
        o_valid <= 1'b1;
        o_data <= mem_reg[rd_ptr_reg];
      end
      else
      begin
        o_valid <= i_valid;
        o_data <= i_data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- brpf_pkg.sv ----
package brpf_pkg;
  // which bus a prefetch request serves
  typedef enum logic {BRPF_PORT_PRI, BRPF_PORT_SEC} brpf_port_e;
  // doubleword amount of one prefetch request
  typedef logic [11:0] brpf_dwords_t;
  // kind of request the sizing logic produced
  typedef enum logic [1:0] {BRPF_KIND_NONE, BRPF_KIND_INITIAL, BRPF_KIND_INCREMENT} brpf_kind_e;
endpackage

// ---- brpf_prefetch_ctrl.sv ----
`include "brpf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module brpf_prefetch_ctrl #(
  parameter int FIFO_DEPTH = `BRPF_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  input wire logic [1:0] i_secondary_initial_prefetch,
  input wire logic [7:0] i_cache_line_size_reg,
  input wire logic i_sec_pcix_mode,
  input wire logic i_p2p_bridging,
  input wire logic i_pri_flow_through,
  input wire logic i_sec_flow_through,
  input wire logic i_pri_read_start,
  input wire logic i_sec_read_start,
  input wire logic i_pri_consume,
  input wire logic i_sec_consume,
  input wire logic i_pri_done,
  input wire logic i_sec_done,
  output logic o_req_valid,
  input wire logic i_req_ready,
  output brpf_pkg::brpf_port_e o_req_port,
  output brpf_pkg::brpf_dwords_t o_req_dwords
);
  import brpf_pkg::*;

  logic [7:0] sec_inc_reg;
  logic [7:0] pri_max_reg;
  logic [7:0] sec_max_reg;
  logic pri_pend_reg;
  logic sec_pend_reg;
  logic pri_act_reg;
  logic sec_act_reg;
  brpf_dwords_t pri_rem_reg;
  brpf_dwords_t sec_rem_reg;
  brpf_dwords_t pri_cum_reg;
  brpf_dwords_t sec_cum_reg;
  logic [6:0] pri_max_dw;
  logic [6:0] sec_max_dw;
  logic [3:0] inc_code;
  brpf_dwords_t inc_dw;
  logic inc_allowed;
  logic inc_due;
  logic pri_capped;
  logic sec_capped;
  brpf_dwords_t pri_init_amt;
  brpf_dwords_t sec_init_amt;
  brpf_dwords_t inc_amt;
  brpf_kind_e sel_kind;
  brpf_port_e sel_port;
  brpf_dwords_t sel_amt;
  logic fifo_in_ready;
  logic push;
  logic [12:0] fifo_out;

  // ==========================================================================
  // decoding helpers

  // maximum field to doublewords; zero means 64 doublewords (256 bytes)
  function automatic logic [6:0] max_dwords(input logic [7:0] field);
    logic [5:0] v;
    v = field[`BRPF_MAX_MSB:0];
    if (v == 6'h00)
      return `BRPF_MAX_ZERO_DWORDS;
    else
      return {1'b0, v};
  endfunction

  // sixteen-line enable bit of the secondary incremental register
  function automatic logic sixteen_en(input logic [7:0] field);
    return field[`BRPF_SEC16_BIT];
  endfunction

  // limit an amount to the room left under the maximum when capping applies
  function automatic brpf_dwords_t cap_amount(input brpf_dwords_t amt, input brpf_dwords_t cum,
                                              input logic [6:0] max_dw, input logic capped);
    brpf_dwords_t lim;
    brpf_dwords_t room;
    lim = {5'h00, max_dw};
    room = (cum >= lim) ? '0 : lim - cum;
    if (capped && amt > room)
      return room;
    else
      return amt;
  endfunction

  // remaining count after a push and a consume in the same cycle
  function automatic brpf_dwords_t next_rem(input brpf_dwords_t rem, input logic add,
                                            input brpf_dwords_t amt, input logic take);
    brpf_dwords_t r;
    r = add ? rem + amt : rem;
    if (take && r != '0)
      r = r - 12'h001;
    return r;
  endfunction

  // ==========================================================================
  // configuration registers

  // byte writes; read-only and reserved bits stay zero
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sec_inc_reg <= `BRPF_SEC_INC_RESET;
      pri_max_reg <= `BRPF_MAX_RESET;
      sec_max_reg <= `BRPF_MAX_RESET;
    end
    else if (i_cfg_wr)
    begin
      case (i_cfg_addr)
        `BRPF_OFF_SEC_INC_PREFETCH:
          sec_inc_reg <= {2'b00, i_cfg_wdata[`BRPF_INC_MSB:`BRPF_SEC16_BIT], 1'b0};
        `BRPF_OFF_PRI_MAX_PREFETCH:
          pri_max_reg <= {2'b00, i_cfg_wdata[`BRPF_MAX_MSB:`BRPF_MAX_WR_LSB], 1'b0};
        `BRPF_OFF_SEC_MAX_PREFETCH:
          sec_max_reg <= {2'b00, i_cfg_wdata[`BRPF_MAX_MSB:`BRPF_MAX_WR_LSB], 1'b0};
        default:
          ;
      endcase
    end
  end

  // registered read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cfg_rdata <= 8'h00;
      o_cfg_rvalid <= 1'b0;
    end
    else
    begin
      o_cfg_rvalid <= i_cfg_rd;
      if (i_cfg_rd)
      begin
        case (i_cfg_addr)
          `BRPF_OFF_SEC_INC_PREFETCH: o_cfg_rdata <= sec_inc_reg;
          `BRPF_OFF_PRI_MAX_PREFETCH: o_cfg_rdata <= pri_max_reg;
          `BRPF_OFF_SEC_MAX_PREFETCH: o_cfg_rdata <= sec_max_reg;
          default: o_cfg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // request sizing

  // decoded limits and incremental amount
  assign pri_max_dw = max_dwords(pri_max_reg);
  assign sec_max_dw = max_dwords(sec_max_reg);
  assign inc_code = sec_inc_reg[`BRPF_INC_MSB:`BRPF_INC_LSB];
  assign inc_dw = brpf_dwords_t'(inc_code) * brpf_dwords_t'(`BRPF_INC_UNIT_DWORDS);
  assign inc_allowed = !i_sec_pcix_mode && (inc_code != 4'h0)
                       && (inc_dw <= brpf_dwords_t'(sec_max_dw >> 1));
  assign pri_capped = i_p2p_bridging && !i_pri_flow_through;
  assign sec_capped = i_p2p_bridging && !i_sec_flow_through;

  // initial amounts: primary always its full maximum
  always_comb
  begin
    logic [4:0] lines;
    lines = 5'h00;
    pri_init_amt = cap_amount({5'h00, pri_max_dw}, pri_cum_reg, pri_max_dw, pri_capped);
    if (sixteen_en(sec_inc_reg))
      lines = `BRPF_SIXTEEN_LINES;
    else
      lines = 5'h01 << i_secondary_initial_prefetch;
    if (i_sec_pcix_mode)
      sec_init_amt = brpf_dwords_t'(lines) * brpf_dwords_t'(i_cache_line_size_reg);
    else
      sec_init_amt = {5'h00, sec_max_dw};
    sec_init_amt = cap_amount(sec_init_amt, sec_cum_reg, sec_max_dw, sec_capped);
  end

  // incremental refill when the entry runs low
  assign inc_due = inc_allowed && sec_act_reg && !sec_pend_reg
                   && (sec_rem_reg < inc_dw);
  assign inc_amt = cap_amount(inc_dw, sec_cum_reg, sec_max_dw, sec_capped);

  // one request per cycle: primary initial, then secondary initial, then increment
  always_comb
  begin
    sel_kind = BRPF_KIND_NONE;
    sel_port = BRPF_PORT_PRI;
    sel_amt = '0;
    if (pri_pend_reg)
    begin
      sel_kind = BRPF_KIND_INITIAL;
      sel_amt = pri_init_amt;
    end
    else if (sec_pend_reg)
    begin
      sel_kind = BRPF_KIND_INITIAL;
      sel_port = BRPF_PORT_SEC;
      sel_amt = sec_init_amt;
    end
    else if (inc_due && inc_amt != '0)
    begin
      sel_kind = BRPF_KIND_INCREMENT;
      sel_port = BRPF_PORT_SEC;
      sel_amt = inc_amt;
    end
  end

  // a zero-sized initial request retires without entering the queue
  assign push = (sel_kind != BRPF_KIND_NONE) && (sel_amt != '0) && fifo_in_ready;

  // ==========================================================================
  // entry tracking

  // pending initial requests; a fresh start wins over the retire
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pri_pend_reg <= 1'b0;
      sec_pend_reg <= 1'b0;
    end
    else
    begin
      if (i_pri_read_start)
        pri_pend_reg <= 1'b1;
      else if (pri_pend_reg && (fifo_in_ready || pri_init_amt == '0))
        pri_pend_reg <= 1'b0;
      if (i_sec_read_start)
        sec_pend_reg <= 1'b1;
      else if (!pri_pend_reg && sec_pend_reg && (fifo_in_ready || sec_init_amt == '0))
        sec_pend_reg <= 1'b0;
    end
  end

  // entry active flags
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pri_act_reg <= 1'b0;
      sec_act_reg <= 1'b0;
    end
    else
    begin
      if (i_pri_read_start)
        pri_act_reg <= 1'b1;
      else if (i_pri_done)
        pri_act_reg <= 1'b0;
      if (i_sec_read_start)
        sec_act_reg <= 1'b1;
      else if (i_sec_done)
        sec_act_reg <= 1'b0;
    end
  end

  // remaining and cumulative doublewords per entry
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pri_rem_reg <= '0;
      sec_rem_reg <= '0;
      pri_cum_reg <= '0;
      sec_cum_reg <= '0;
    end
    else
    begin
      if (i_pri_read_start || i_pri_done)
      begin
        pri_rem_reg <= '0;
        pri_cum_reg <= '0;
      end
      else
      begin
        pri_rem_reg <= next_rem(pri_rem_reg, push && sel_port == BRPF_PORT_PRI, sel_amt,
                                i_pri_consume);
        if (push && sel_port == BRPF_PORT_PRI)
          pri_cum_reg <= pri_cum_reg + sel_amt;
      end
      if (i_sec_read_start || i_sec_done)
      begin
        sec_rem_reg <= '0;
        sec_cum_reg <= '0;
      end
      else
      begin
        sec_rem_reg <= next_rem(sec_rem_reg, push && sel_port == BRPF_PORT_SEC, sel_amt,
                                i_sec_consume);
        if (push && sel_port == BRPF_PORT_SEC)
          sec_cum_reg <= sec_cum_reg + sel_amt;
      end
    end
  end

  // ==========================================================================
  // request queue toward the prefetch datapath

  // request word is {port, doublewords}
  brpf_fifo #(
    .WIDTH(13),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_valid(push),
    .o_ready(fifo_in_ready),
    .i_data({sel_port, sel_amt}),
    .o_valid(o_req_valid),
    .i_ready(i_req_ready),
    .o_data(fifo_out)
  );

  // split the queue word onto the output ports
  assign o_req_port = brpf_port_e'(fifo_out[12]);
  assign o_req_dwords = fifo_out[11:0];
endmodule
`default_nettype wire

// ---- brpf_req_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// request sink standing in for the prefetch datapath
module brpf_req_sink (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire brpf_pkg::brpf_port_e i_port,
  input wire brpf_pkg::brpf_dwords_t i_dwords,
  output logic o_ready,
  output logic [7:0] o_count,
  output logic [15:0] o_last
);
  import brpf_pkg::*;
  logic [1:0] div_reg;
  // ready every cycle, or one cycle in four while stalling
  assign o_ready = !i_slow || div_reg == 2'h3;
  // divider for the stall pattern
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1;
  // log each accepted request as port over dwords
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_count <= 8'h00;
      o_last <= 16'h0000;
    end
    else if (i_valid && o_ready)
    begin
      o_count <= o_count + 8'h01;
      o_last <= {3'h0, i_port, i_dwords};
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// self-checking bench for the prefetch sizing block
module tb;
  import brpf_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_cfg_wr = 1'b0;
  logic i_cfg_rd = 1'b0;
  logic [7:0] i_cfg_addr = 8'h00;
  logic [7:0] i_cfg_wdata = 8'h00;
  logic [1:0] init = 2'h0;
  logic pcix = 1'b0;
  logic pft = 1'b0;
  logic sft = 1'b1;
  logic p2p = 1'b1;
  logic slow = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0] o_cfg_rdata;
  logic o_cfg_rvalid;
  logic o_req_valid;
  logic ready;
  brpf_port_e o_req_port;
  brpf_dwords_t o_req_dwords;
  logic [7:0] cnt;
  logic [15:0] last;
  int err_count = 0;
  int comparisons = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  brpf_prefetch_ctrl brpf_prefetch_ctrl_i (.i_clk, .i_rstn, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
    .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rvalid, .i_secondary_initial_prefetch(init),
    .i_cache_line_size_reg(8'h04), .i_sec_pcix_mode(pcix), .i_p2p_bridging(p2p),
    .i_pri_flow_through(pft), .i_sec_flow_through(sft), .i_pri_read_start(ev[0]),
    .i_sec_read_start(ev[1]), .i_pri_consume(ev[2]), .i_sec_consume(ev[3]),
    .i_pri_done(ev[4]), .i_sec_done(ev[5]), .o_req_valid, .i_req_ready(ready), .o_req_port,
    .o_req_dwords);
  brpf_req_sink brpf_req_sink_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_slow(slow),
    .i_valid(o_req_valid), .i_port(o_req_port), .i_dwords(o_req_dwords), .o_ready(ready),
    .o_count(cnt), .o_last(last));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_cfg_wr = 1'b1;
    i_cfg_addr = a;
    i_cfg_wdata = d;
    @(negedge i_clk);
    i_cfg_wr = 1'b0;
  endtask
  // read result carries rvalid above the data byte
  task automatic cfg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_clk);
    i_cfg_rd = 1'b1;
    i_cfg_addr = a;
    @(negedge i_clk);
    i_cfg_rd = 1'b0;
    d = {7'h00, o_cfg_rvalid, o_cfg_rdata};
  endtask
  task automatic pulse(input int b);
    @(negedge i_clk);
    ev[b] = 1'b1;
    @(negedge i_clk);
    ev[b] = 1'b0;
  endtask
  task automatic get_req(output logic [15:0] r);
    logic [7:0] n0;
    n0 = cnt;
    for (int i = 0; i < 60 && cnt == n0; i++)
      @(negedge i_clk);
    r = (cnt == n0) ? 16'hffff : last;
  endtask
  task automatic no_req(output logic [15:0] r);
    logic [7:0] n0;
    n0 = cnt;
    repeat (40) @(negedge i_clk);
    r = {8'h00, cnt - n0};
  endtask
  task automatic t_regs();
    logic [15:0] r;
    for (int i = 0; i < 3; i++)
    begin
      cfg_rd(8'h4b + i[7:0], r);
      check(r, (i == 0) ? 16'h0100 : 16'h0120);
      cfg_wr(8'h4b + i[7:0], 8'hff);
      cfg_rd(8'h4b + i[7:0], r);
      check(r, 16'h013e);
    end
    cfg_wr(8'h4e, 8'hff);
    cfg_rd(8'h4e, r);
    check(r, 16'h0100);
  endtask
  task automatic t_pri();
    logic [15:0] r;
    cfg_wr(8'h4c, 8'h11);
    pulse(0);
    get_req(r);
    check(r, 16'h0010);
    pulse(4);
    cfg_wr(8'h4c, 8'h00);
    pulse(0);
    get_req(r);
    check(r, 16'h0040);
    pulse(4);
    cfg_wr(8'h4c, 8'h20);
  endtask
  task automatic sec_case(input logic [3:0] code, input logic [7:0] mx, input int n,
                          input logic [15:0] exp);
    logic [15:0] r;
    cfg_wr(8'h4d, mx);
    cfg_wr(8'h4b, {2'h0, code, 2'h0});
    pulse(1);
    get_req(r);
    check(r, {8'h10, (mx == 8'h00) ? 8'h40 : mx});
    repeat (n) pulse(3);
    if (exp == 16'h0000)
      no_req(r);
    else
      get_req(r);
    check(r, exp);
    pulse(5);
  endtask
  task automatic t_pcix();
    logic [15:0] r;
    pcix = 1'b1;
    cfg_wr(8'h4b, 8'h08);
    for (int c = 0; c < 4; c++)
    begin
      init = c[1:0];
      pulse(1);
      get_req(r);
      check(r, 16'h1000 | (16'h0004 << c));
      pulse(5);
    end
    cfg_wr(8'h4b, 8'h0a);
    pulse(1);
    get_req(r);
    check(r, 16'h1040);
    repeat (57) pulse(3);
    no_req(r);
    check(r, 16'h0000);
    pulse(5);
    pcix = 1'b0;
  endtask
  task automatic t_stall();
    logic [15:0] r;
    slow = 1'b1;
    pulse(0);
    pulse(1);
    get_req(r);
    check(r, 16'h0020);
    get_req(r);
    check(r, 16'h1020);
    pulse(4);
    pulse(5);
    slow = 1'b0;
  endtask
  // mid-run reset returns registers and outputs to their reset values
  task automatic t_reset();
    logic [15:0] r;
    cfg_wr(8'h4c, 8'h10);
    cfg_wr(8'h4b, 8'h0e);
    cfg_rd(8'h4c, r);
    @(negedge i_clk);
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clk);
    check({o_req_valid, o_cfg_rvalid, o_cfg_rdata}, 16'h0000);
    i_rstn = 1'b1;
    cfg_rd(8'h4b, r);
    check(r, 16'h0100);
    cfg_rd(8'h4c, r);
    check(r, 16'h0120);
    pulse(0);
    get_req(r);
    check(r, 16'h0020);
    pulse(4);
  endtask
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_rstn = 1'b1;
    t_regs();
    t_pri();
    sec_case(4'h2, 8'h20, 24, 16'h0000);
    sec_case(4'h2, 8'h20, 25, 16'h1008);
    sec_case(4'h8, 8'h00, 33, 16'h1020);
    sec_case(4'h9, 8'h00, 40, 16'h0000);
    sec_case(4'h0, 8'h20, 31, 16'h0000);
    sft = 1'b0;
    sec_case(4'h2, 8'h20, 25, 16'h0000);
    p2p = 1'b0;
    sec_case(4'h2, 8'h20, 25, 16'h1008);
    p2p = 1'b1;
    sft = 1'b1;
    t_pcix();
    t_stall();
    t_reset();
    stop_test();
  end
  // watchdog
  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
